// File: isc_ctrl.sv
/*
  Impedance sweep control: two-wire serial slave, register bank, command decode,
  sweep sequencer and temperature request.
  Assumes the synthesizer pulses excitation_cycle_in once per excitation period in
  this clock domain, and that converter and sensor answer with one-cycle done pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module isc_ctrl
#(
	parameter logic [6:0] DEV_ADDR = 7'h0D	// Arbitrary bus address
)
(
	input  wire logic                         clk_sys_in,
	input  wire logic                         sys_rst_in,
	input  wire logic                         scl_in,
	input  wire logic                         sda_in,
	output logic                              sda_out,
	output logic                              sda_oe_n_out,
	input  wire logic                         excitation_cycle_in,
	input  wire logic                         adc_done_in,
	input  wire logic [15:0]                  inphase_in,
	input  wire logic [15:0]                  quadrature_in,
	input  wire logic                         temp_done_in,
	input  wire logic [isc_pkg::TEMP_W-1:0]   temp_code_in,
	output logic [23:0]                       synth_freq_code_out,
	output var isc_pkg::isc_afe_s             afe_out,
	output logic                              adc_start_out,
	output logic                              temp_start_out,
	output logic                              temp_sensor_power_out
);
	import isc_pkg::*;

	// Settling target in excitation cycles
	function automatic logic [SETTLE_W-1:0] settle_target(input logic [15:0] raw);
		logic [SETTLE_W-1:0] base;
		base = {2'h0, raw[8:0]};
		unique case (raw[SETTLE_MULT_LSB+1:SETTLE_MULT_LSB])
			MULT_X2: settle_target = base << 1;
			MULT_X4: settle_target = base << 2;
			default: settle_target = base;	// Reserved code acts as times one
		endcase
	endfunction

	logic                scl_s1_reg, scl_s2_reg, scl_s3_reg;
	logic                sda_s1_reg, sda_s2_reg, sda_s3_reg;
	logic                scl_rise, scl_fall, bus_start, bus_stop;
	isc_bus_e            bus_state_reg;
	logic [3:0]          bit_cnt_reg;
	logic [1:0]          byte_num_reg;
	logic [7:0]          rx_shift_reg;
	logic [7:0]          tx_shift_reg;
	logic [7:0]          ptr_reg;
	logic                rw_reg;
	logic                drive_low_reg;
	logic [7:0]          rd_byte;
	logic                wr_en;
	logic [15:0]         ctrl_reg;
	logic [23:0]         first_reg, step_reg;
	logic [15:0]         pts_reg, settle_reg;
	logic [15:0]         temp_reg, inph_reg, quad_reg;
	logic [2:0]          flags_reg;
	logic                cmd_pulse, srst_pulse;
	logic [3:0]          cmd;
	isc_power_e          power_reg;
	isc_sweep_e          sweep_reg;
	logic [23:0]         freq_reg;
	logic [PTS_W-1:0]    idx_reg;
	logic [SETTLE_W-1:0] settle_cnt_reg;
	logic                temp_busy_reg;
	logic                adc_start_reg, temp_start_reg;
	logic                meas_go, armed_reg;

	// Two-stage synchronisers plus one history stage for edge detection
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			scl_s3_reg <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_s3_reg <= 1'b1;
		end
		else
		begin
			scl_s1_reg <= scl_in;
			scl_s2_reg <= scl_s1_reg;
			scl_s3_reg <= scl_s2_reg;
			sda_s1_reg <= sda_in;
			sda_s2_reg <= sda_s1_reg;
			sda_s3_reg <= sda_s2_reg;
		end
	end

	// Bus events seen only on synchronised copies
	assign scl_rise  = scl_s2_reg & ~scl_s3_reg;
	assign scl_fall  = ~scl_s2_reg & scl_s3_reg;
	assign bus_start = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
	assign bus_stop  = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

	// Third and later bytes of a write are register data
	assign wr_en = (bus_state_reg == BS_RX) && scl_fall && (bit_cnt_reg == 4'h8)
		&& (byte_num_reg == 2'h2);

	// Serial slave: address, pointer, then data bytes with auto-increment
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			bus_state_reg <= BS_IDLE;
			bit_cnt_reg   <= 4'h0;
			byte_num_reg  <= 2'h0;
			rx_shift_reg  <= 8'h00;
			tx_shift_reg  <= 8'h00;
			ptr_reg       <= 8'h00;
			rw_reg        <= 1'b0;
			drive_low_reg <= 1'b0;
		end
		else if (bus_start)
		begin
			bus_state_reg <= BS_RX;
			bit_cnt_reg   <= 4'h0;
			byte_num_reg  <= 2'h0;
			drive_low_reg <= 1'b0;
		end
		else if (bus_stop)
		begin
			bus_state_reg <= BS_IDLE;
			drive_low_reg <= 1'b0;
		end
		else
		begin
			unique case (bus_state_reg)
				BS_IDLE: ;
				BS_RX:
				begin
					if (scl_rise)
					begin
						rx_shift_reg <= {rx_shift_reg[6:0], sda_s2_reg};
						bit_cnt_reg  <= bit_cnt_reg + 4'h1;
					end
					else if (scl_fall && bit_cnt_reg == 4'h8)
					begin
						bit_cnt_reg <= 4'h0;
						if (byte_num_reg != 2'h0 || rx_shift_reg[7:1] == DEV_ADDR)
						begin
							bus_state_reg <= BS_ACK;
							drive_low_reg <= 1'b1;
						end
						else
							bus_state_reg <= BS_IDLE;	// Not our address
						if (byte_num_reg == 2'h0)
							rw_reg <= rx_shift_reg[0];
						else if (byte_num_reg == 2'h1)
							ptr_reg <= rx_shift_reg;
						else
							ptr_reg <= ptr_reg + 8'h01;	// Step past the byte just written
					end
				end
				BS_ACK:
				begin
					if (scl_fall)
					begin
						if (byte_num_reg != 2'h2)
							byte_num_reg <= byte_num_reg + 2'h1;
						if (rw_reg)
						begin
							bus_state_reg <= BS_TX;
							tx_shift_reg  <= rd_byte;
							drive_low_reg <= ~rd_byte[7];
							bit_cnt_reg   <= 4'h1;
						end
						else
						begin
							bus_state_reg <= BS_RX;
							drive_low_reg <= 1'b0;
						end
					end
				end
				BS_TX:
				begin
					if (scl_fall)
					begin
						if (bit_cnt_reg == 4'h8)
						begin
							bus_state_reg <= BS_RACK;
							drive_low_reg <= 1'b0;
							ptr_reg       <= ptr_reg + 8'h01;
						end
						else
						begin
							tx_shift_reg  <= {tx_shift_reg[6:0], 1'b0};
							drive_low_reg <= ~tx_shift_reg[6];
							bit_cnt_reg   <= bit_cnt_reg + 4'h1;
						end
					end
				end
				BS_RACK:
				begin
					// Master not-acknowledge ends the read
					if (scl_rise && sda_s2_reg)
						bus_state_reg <= BS_IDLE;
					else if (scl_fall)
					begin
						bus_state_reg <= BS_TX;
						tx_shift_reg  <= rd_byte;
						drive_low_reg <= ~rd_byte[7];
						bit_cnt_reg   <= 4'h1;
					end
				end
			endcase
		end
	end

	// Open-drain: only ever pulls low
	assign sda_out      = 1'b0;
	assign sda_oe_n_out = ~drive_low_reg;

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		unique case (ptr_reg)
			ADDR_CTRL_HI:   rd_byte = ctrl_reg[15:8];
			ADDR_CTRL_LO:   rd_byte = ctrl_reg[7:0];
			ADDR_FIRST_2:   rd_byte = first_reg[23:16];
			ADDR_FIRST_1:   rd_byte = first_reg[15:8];
			ADDR_FIRST_0:   rd_byte = first_reg[7:0];
			ADDR_STEP_2:    rd_byte = step_reg[23:16];
			ADDR_STEP_1:    rd_byte = step_reg[15:8];
			ADDR_STEP_0:    rd_byte = step_reg[7:0];
			ADDR_PTS_HI:    rd_byte = pts_reg[15:8];
			ADDR_PTS_LO:    rd_byte = pts_reg[7:0];
			ADDR_SETTLE_HI: rd_byte = settle_reg[15:8];
			ADDR_SETTLE_LO: rd_byte = settle_reg[7:0];
			ADDR_FLAGS:     rd_byte = {5'h00, flags_reg};
			ADDR_TEMP_HI:   rd_byte = temp_reg[15:8];
			ADDR_TEMP_LO:   rd_byte = temp_reg[7:0];
			ADDR_INPH_HI:   rd_byte = inph_reg[15:8];
			ADDR_INPH_LO:   rd_byte = inph_reg[7:0];
			ADDR_QUAD_HI:   rd_byte = quad_reg[15:8];
			ADDR_QUAD_LO:   rd_byte = quad_reg[7:0];
			default:        rd_byte = 8'h00;
		endcase
	end

	// Command acts on any write of the upper byte; soft reset on lower byte
	assign cmd_pulse  = wr_en && (ptr_reg == ADDR_CTRL_HI);
	assign cmd        = rx_shift_reg[7:4];
	assign srst_pulse = wr_en && (ptr_reg == ADDR_CTRL_LO) && rx_shift_reg[CTRL_SRST_BIT];

	// Control register, bytes written independently
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			ctrl_reg <= CTRL_RESET;
		else if (wr_en && ptr_reg == ADDR_CTRL_HI)
			ctrl_reg[15:8] <= rx_shift_reg;
		else if (wr_en && ptr_reg == ADDR_CTRL_LO)
			ctrl_reg[7:0] <= rx_shift_reg;
	end

	// Sweep setup registers have no reset and survive soft reset
	always_ff @(posedge clk_sys_in)
	begin
		if (wr_en)
		begin
			unique case (ptr_reg)
				ADDR_FIRST_2:   first_reg[23:16] <= rx_shift_reg;
				ADDR_FIRST_1:   first_reg[15:8]  <= rx_shift_reg;
				ADDR_FIRST_0:   first_reg[7:0]   <= rx_shift_reg;
				ADDR_STEP_2:    step_reg[23:16]  <= rx_shift_reg;
				ADDR_STEP_1:    step_reg[15:8]   <= rx_shift_reg;
				ADDR_STEP_0:    step_reg[7:0]    <= rx_shift_reg;
				ADDR_PTS_HI:    pts_reg[15:8]    <= rx_shift_reg;
				ADDR_PTS_LO:    pts_reg[7:0]     <= rx_shift_reg;
				ADDR_SETTLE_HI: settle_reg[15:8] <= rx_shift_reg;
				ADDR_SETTLE_LO: settle_reg[7:0]  <= rx_shift_reg;
				default: ;
			endcase
		end
	end

	// Power mode follows mode commands; undefined codes change nothing
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			power_reg <= PWR_DOWN;
		else if (cmd_pulse && cmd == CMD_PDOWN)
			power_reg <= PWR_DOWN;
		else if (cmd_pulse && cmd == CMD_STBY)
			power_reg <= PWR_STBY;
		else if (cmd_pulse && cmd == CMD_INIT)
			power_reg <= PWR_ACTIVE;
	end

	// Sweep measures from hold; increment and repeat only once a sweep has begun
	assign meas_go = cmd_pulse && (sweep_reg == SW_HOLD)
		&& (cmd == CMD_SWEEP || ((cmd == CMD_INC || cmd == CMD_REPEAT) && armed_reg));

	// Armed by start sweep; init, mode change or soft reset disarm it
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			armed_reg <= 1'b0;
		else if (srst_pulse || (cmd_pulse && (cmd == CMD_INIT || cmd == CMD_PDOWN || cmd == CMD_STBY)))
			armed_reg <= 1'b0;
		else if (meas_go && cmd == CMD_SWEEP)
			armed_reg <= 1'b1;
	end

	// Sweep sequencer
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			sweep_reg      <= SW_IDLE;
			freq_reg       <= 24'h000000;
			idx_reg        <= '0;
			settle_cnt_reg <= '0;
			adc_start_reg  <= 1'b0;
		end
		else
		begin
			adc_start_reg <= 1'b0;
			if (srst_pulse || (cmd_pulse && (cmd == CMD_PDOWN || cmd == CMD_STBY)))
				sweep_reg <= SW_IDLE;
			else if (cmd_pulse && cmd == CMD_INIT)
			begin
				sweep_reg <= SW_HOLD;
				freq_reg  <= first_reg;
				idx_reg   <= '0;
			end
			else if (meas_go)
			begin
				sweep_reg      <= SW_SETTLE;
				settle_cnt_reg <= '0;
				// Step only while points remain, else remeasure the last one
				if (cmd == CMD_INC && idx_reg < pts_reg[PTS_W-1:0])
				begin
					freq_reg <= freq_reg + step_reg;
					idx_reg  <= idx_reg + 1'b1;
				end
			end
			else
			begin
				unique case (sweep_reg)
					SW_IDLE, SW_HOLD: ;
					SW_SETTLE:
					begin
						if (settle_cnt_reg >= settle_target(settle_reg))
						begin
							sweep_reg     <= SW_CONVERT;
							adc_start_reg <= 1'b1;
						end
						else if (excitation_cycle_in)
							settle_cnt_reg <= settle_cnt_reg + 1'b1;
					end
					SW_CONVERT:
					begin
						if (adc_done_in)
							sweep_reg <= SW_HOLD;
					end
				endcase
			end
		end
	end

	// Results are captured as the converter reports them
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			inph_reg <= 16'h0000;
			quad_reg <= 16'h0000;
		end
		else if (sweep_reg == SW_CONVERT && adc_done_in)
		begin
			inph_reg <= inphase_in;
			quad_reg <= quadrature_in;
		end
	end

	// Temperature request runs beside the sweep in any power mode
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			temp_busy_reg  <= 1'b0;
			temp_start_reg <= 1'b0;
			temp_reg       <= 16'h0000;
		end
		else
		begin
			temp_start_reg <= cmd_pulse && cmd == CMD_TEMP && !temp_busy_reg;
			if (cmd_pulse && cmd == CMD_TEMP)
				temp_busy_reg <= 1'b1;
			else if (temp_done_in && temp_busy_reg)
			begin
				temp_busy_reg <= 1'b0;
				temp_reg      <= {{(16-TEMP_W){temp_code_in[TEMP_W-1]}}, temp_code_in};
			end
		end
	end

	// Flags: clears first, so a same-cycle set wins
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			flags_reg <= 3'h0;
		else
		begin
			if (srst_pulse || meas_go)
				flags_reg[FLAG_DATA] <= 1'b0;
			if (srst_pulse || (meas_go && cmd == CMD_SWEEP))
				flags_reg[FLAG_DONE] <= 1'b0;
			if (cmd_pulse && cmd == CMD_TEMP)
				flags_reg[FLAG_TEMP] <= 1'b0;
			if (sweep_reg == SW_CONVERT && adc_done_in)
			begin
				flags_reg[FLAG_DATA] <= 1'b1;
				if (idx_reg >= pts_reg[PTS_W-1:0])
					flags_reg[FLAG_DONE] <= 1'b1;
			end
			if (temp_done_in && temp_busy_reg)
				flags_reg[FLAG_TEMP] <= 1'b1;
		end
	end

	// Front end controls; bit 11 and reserved bits drive nothing
	always_ff @(posedge clk_sys_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			afe_out <= '{range: 2'h0, gain_unity: 1'b0, ext_clk: 1'b0,
				grounded: 1'b1, powered: 1'b0, synth_run: 1'b0};
		else
		begin
			afe_out.range      <= ctrl_reg[CTRL_RANGE_LSB+1:CTRL_RANGE_LSB];
			afe_out.gain_unity <= ctrl_reg[CTRL_GAIN_BIT];
			afe_out.ext_clk    <= ctrl_reg[CTRL_EXTCLK_BIT];
			afe_out.grounded   <= (power_reg != PWR_ACTIVE);
			afe_out.powered    <= (power_reg != PWR_DOWN);
			afe_out.synth_run  <= (power_reg == PWR_ACTIVE) && (sweep_reg != SW_IDLE);
		end
	end

	// Frequency code goes to the synthesizer unchanged
	assign synth_freq_code_out   = freq_reg;
	assign adc_start_out         = adc_start_reg;
	assign temp_start_out        = temp_start_reg;
	assign temp_sensor_power_out = temp_busy_reg;

endmodule
`default_nettype wire

// File: isc_ctrl_props.sv
/*
  Port checker of isc_ctrl: pulse widths, pin grounding, serial pin timing.
  Assumes a bind to isc_ctrl; one clock, reset active high.
*/
`timescale 1ns/10ps
`default_nettype none
module isc_ctrl_props
(
	input wire logic              clk_sys_in,
	input wire logic              sys_rst_in,
	input wire logic              scl_in,
	input wire logic              sda_out,
	input wire logic              sda_oe_n_out,
	input wire logic              temp_done_in,
	input wire isc_pkg::isc_afe_s afe_out,
	input wire logic              adc_start_out,
	input wire logic              temp_start_out,
	input wire logic              temp_sensor_power_out
);
	import isc_pkg::*;

	// One domain, so one clock and one disable
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);

	// Analog front end
	gnd_when_off_a : assert property (!afe_out.powered |-> afe_out.grounded)
		else $error("pins not grounded while unpowered");
	conv_when_live_a : assert property (adc_start_out |-> afe_out.synth_run && !afe_out.grounded)
		else $error("conversion without live excitation");
	conv_pulse_a : assert property (adc_start_out |=> !adc_start_out)
		else $error("conversion start longer than one cycle");
	field_scl_low_a : assert property (!$stable({afe_out.range, afe_out.gain_unity, afe_out.ext_clk}) |-> !scl_in)
		else $error("front end field changed outside a byte end");

	// Temperature request
	temp_power_on_a : assert property (temp_start_out |-> temp_sensor_power_out)
		else $error("sensor unpowered at conversion start");
	temp_power_off_a : assert property ($fell(temp_sensor_power_out) |-> $past(temp_done_in))
		else $error("sensor powered down before its result");
	temp_pulse_a : assert property (temp_start_out |=> !temp_start_out)
		else $error("sensor start longer than one cycle");

	// Serial pin: only pulls low, moves only while clock is low
	sda_low_only_a : assert property (!sda_oe_n_out |-> !sda_out)
		else $error("data pin driven high");
	ack_scl_low_a : assert property ($changed(sda_oe_n_out) |-> !scl_in && !$past(scl_in))
		else $error("data pin moved while clock high");

	// Main scenarios reached
	conv_c : cover property (adc_start_out);
	temp_c : cover property (temp_start_out);
	live_c : cover property (afe_out.synth_run && !afe_out.grounded);
endmodule
`default_nettype wire

// File: isc_host.sv
/*
  Behavioural serial bus host for isc_ctrl, with a pull-up on the data wire.
  Assumes its clock is the system clock; changes pins after falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
module isc_host
#(
	parameter logic [6:0] DEV_ADDR = 7'h0D	// Arbitrary bus address
)
(
	input  wire logic  clk_sys_in,
	input  wire logic  sda_dev_in,
	input  wire logic  sda_oe_n_in,
	output logic       scl_out,
	output logic       sda_out,
	output logic       rd_done_out,
	output logic [7:0] rd_byte_out
);
	logic drv;	// High means released

	// Wire level: pull-up, either party may pull low
	assign sda_out = drv & (sda_oe_n_in | sda_dev_in);

	// Idle bus at time zero
	initial
	begin
		scl_out = 1'b1;
		drv = 1'b1;
		rd_done_out = 1'b0;
		rd_byte_out = 8'h00;
	end

	// Clock phases of at least 4 cycles keep every level past the synchroniser
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask

	task automatic bit_io(input logic b, output logic s);
		drv = b;
		wt(3);
		scl_out = 1'b1;
		wt(3);
		s = sda_out;
		wt(3);
		scl_out = 1'b0;
		wt(2);
	endtask

	// Ninth bit: always released; after read data the high level is a not-acknowledge (ends the read)
	task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(b[i], s);
			r[i] = s;
		end
		bit_io(1'b1, s);
		ack = !s;
	endtask

	task automatic start();
		drv = 1'b1;
		wt(2);
		scl_out = 1'b1;
		wt(4);
		drv = 1'b0;
		wt(4);
		scl_out = 1'b0;
		wt(2);
	endtask

	task automatic stop();
		drv = 1'b0;
		wt(2);
		scl_out = 1'b1;
		wt(4);
		drv = 1'b1;
		wt(4);
	endtask

	// One data byte per transaction, so control is never block written
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2;
		start();
		byte_io({dev, 1'b0}, r, a0);
		byte_io(ptr, r, a1);
		byte_io(d, r, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask

	task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
		logic [7:0] r;
		logic a;
		start();
		byte_io({DEV_ADDR, 1'b0}, r, a);
		byte_io(ptr, r, a);
		stop();
		start();
		byte_io({DEV_ADDR, 1'b1}, r, a);
		byte_io(8'hFF, d, a);
		stop();
		rd_byte_out = d;
		rd_done_out = 1'b1;
		wt(1);
		rd_done_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: isc_pkg.sv
/*
  Shared constants and types of the impedance sweep control block:
  register byte addresses, control fields, command codes, flag bits and state codes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package isc_pkg;

	// Register byte addresses on the serial bus
	localparam logic [7:0] ADDR_CTRL_HI   = 8'h80;
	localparam logic [7:0] ADDR_CTRL_LO   = 8'h81;
	localparam logic [7:0] ADDR_FIRST_2   = 8'h82;
	localparam logic [7:0] ADDR_FIRST_1   = 8'h83;
	localparam logic [7:0] ADDR_FIRST_0   = 8'h84;
	localparam logic [7:0] ADDR_STEP_2    = 8'h85;
	localparam logic [7:0] ADDR_STEP_1    = 8'h86;
	localparam logic [7:0] ADDR_STEP_0    = 8'h87;
	localparam logic [7:0] ADDR_PTS_HI    = 8'h88;
	localparam logic [7:0] ADDR_PTS_LO    = 8'h89;
	localparam logic [7:0] ADDR_SETTLE_HI = 8'h8A;
	localparam logic [7:0] ADDR_SETTLE_LO = 8'h8B;
	localparam logic [7:0] ADDR_FLAGS     = 8'h8F;
	localparam logic [7:0] ADDR_TEMP_HI   = 8'h92;
	localparam logic [7:0] ADDR_TEMP_LO   = 8'h93;
	localparam logic [7:0] ADDR_INPH_HI   = 8'h94;
	localparam logic [7:0] ADDR_INPH_LO   = 8'h95;
	localparam logic [7:0] ADDR_QUAD_HI   = 8'h96;
	localparam logic [7:0] ADDR_QUAD_LO   = 8'h97;

	// Control register reset value and field positions
	localparam logic [15:0] CTRL_RESET      = 16'hA000;
	localparam int          CTRL_RANGE_LSB  = 9;
	localparam int          CTRL_GAIN_BIT   = 8;
	localparam int          CTRL_SRST_BIT   = 4;
	localparam int          CTRL_EXTCLK_BIT = 3;

	// Command codes in the top control nibble
	localparam logic [3:0] CMD_INIT   = 4'h1;
	localparam logic [3:0] CMD_SWEEP  = 4'h2;
	localparam logic [3:0] CMD_INC    = 4'h3;
	localparam logic [3:0] CMD_REPEAT = 4'h4;
	localparam logic [3:0] CMD_TEMP   = 4'h9;
	localparam logic [3:0] CMD_PDOWN  = 4'hA;
	localparam logic [3:0] CMD_STBY   = 4'hB;

	// Settling multiplier field and widths
	localparam int         SETTLE_MULT_LSB = 9;
	localparam logic [1:0] MULT_X2         = 2'h1;
	localparam logic [1:0] MULT_X4         = 2'h3;
	localparam int         PTS_W           = 9;
	localparam int         SETTLE_W        = 11;
	localparam int         TEMP_W          = 14;

	// Flag register bit positions
	localparam int FLAG_TEMP = 0;
	localparam int FLAG_DATA = 1;
	localparam int FLAG_DONE = 2;

	typedef enum logic [2:0]
	{
		PWR_DOWN   = 3'b001,
		PWR_STBY   = 3'b010,
		PWR_ACTIVE = 3'b100
	} isc_power_e;

	typedef enum logic [3:0]
	{
		SW_IDLE    = 4'b0001,
		SW_HOLD    = 4'b0010,
		SW_SETTLE  = 4'b0100,
		SW_CONVERT = 4'b1000
	} isc_sweep_e;

	typedef enum logic [4:0]
	{
		BS_IDLE = 5'b00001,
		BS_RX   = 5'b00010,
		BS_ACK  = 5'b00100,
		BS_TX   = 5'b01000,
		BS_RACK = 5'b10000
	} isc_bus_e;

	// Analog front end controls
	typedef struct packed
	{
		logic [1:0] range;
		logic       gain_unity;
		logic       ext_clk;
		logic       grounded;
		logic       powered;
		logic       synth_run;
	} isc_afe_s;

endpackage
`default_nettype wire

// File: tb.sv
/*
  Self-checking bench of isc_ctrl: host model on the serial pins, converter,
  sensor and excitation pulses modelled here.
  Assumes isc_pkg, isc_host and isc_ctrl_props are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
	import isc_pkg::*;
	localparam logic [6:0] DEV = 7'h0D;	// Arbitrary bus address

	logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, scl, sda, sda_o, sda_oe_n, rd_done;
	logic exc = 1'b0, exc_en = 1'b0, adc_done = 1'b0, temp_done = 1'b0;
	logic adc_start, temp_start, temp_pwr;
	logic [15:0] inph = 16'h0000, quad = 16'h0000;
	logic [13:0] tcode = 14'h0000;
	logic [23:0] freq, first, step;
	logic [7:0] rd_byte, exp_q[$];
	isc_afe_s afe;
	int fails = 0, checked = 0, cyc = 0, exc_cnt = 0, starts = 0, at_start = 0, adc_wait = 0, temp_wait = 0;

	isc_ctrl #(.DEV_ADDR(DEV)) i_isc_ctrl (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .excitation_cycle_in(exc), .adc_done_in(adc_done),
		.inphase_in(inph), .quadrature_in(quad), .temp_done_in(temp_done), .temp_code_in(tcode),
		.synth_freq_code_out(freq), .afe_out(afe), .adc_start_out(adc_start), .temp_start_out(temp_start),
		.temp_sensor_power_out(temp_pwr));
	isc_host #(.DEV_ADDR(DEV)) i_isc_host (.clk_sys_in(clk_sys_in), .sda_dev_in(sda_o), .sda_oe_n_in(sda_oe_n),
		.scl_out(scl), .sda_out(sda), .rd_done_out(rd_done), .rd_byte_out(rd_byte));

	// 40 MHz clock
	initial
	begin
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp)
		begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		i_isc_host.wr(DEV, a, d, ok);
		check(ok, 1);
	endtask

	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		exp_q.push_back(e);
		i_isc_host.rd(a, d);
	endtask

	// Read results against the oldest note; hang guard
	always @(posedge clk_sys_in)
	begin
		cyc++;
		if (rd_done)
			check(rd_byte, exp_q.pop_front());
		if (cyc == 90000)
		begin
			fails++;
			wrap_up();
		end
	end

	// Far side: gated excitation pulses, converter and sensor answers
	always @(negedge clk_sys_in)
	begin
		exc = exc_en && (cyc % 4 == 0);
		exc_cnt = exc_en ? exc_cnt + int'(exc) : 0;
		adc_done = (adc_wait == 1);
		if (adc_done)
		begin
			inph = 16'($urandom);
			quad = 16'($urandom);
		end
		if (adc_wait > 0)
			adc_wait--;
		if (adc_start)
		begin
			adc_wait = 3;
			starts++;
			at_start = exc_cnt;
		end
		temp_done = (temp_wait == 1);
		if (temp_done)
			tcode = 14'($urandom);
		if (temp_wait > 0)
			temp_wait--;
		if (temp_start)
			temp_wait = 5;
	end

	// One point: settle setup, command, settle count, results and flags
	task automatic measure(input logic [3:0] cmd, input logic [1:0] m, input logic [23:0] f, input logic dn0,
		input logic dn1);
		int n, t, k;
		n = $urandom_range(1, 6);
		t = n * ((m == MULT_X2) ? 2 : (m == MULT_X4) ? 4 : 1);
		wr(ADDR_SETTLE_HI, {5'h00, m, 1'b0});
		wr(ADDR_SETTLE_LO, n[7:0]);
		wr(ADDR_CTRL_HI, {cmd, 4'h0});
		rd_exp(ADDR_FLAGS, {5'h00, dn0, 2'b00});
		exc_en = 1'b1;
		k = 0;
		while (!adc_done && k < 400)
		begin
			@(posedge clk_sys_in);
			k++;
		end
		@(negedge clk_sys_in);
		exc_en = 1'b0;
		check(k < 400, 1'b1);
		check(at_start, t);
		check(freq, f);
		rd_exp(ADDR_INPH_HI, inph[15:8]);
		rd_exp(ADDR_INPH_LO, inph[7:0]);
		rd_exp(ADDR_QUAD_HI, quad[15:8]);
		rd_exp(ADDR_QUAD_LO, quad[7:0]);
		rd_exp(ADDR_FLAGS, {5'h00, dn1, 2'b10});
	endtask

	// Main sequence
	initial
	begin
		logic ok;
		logic [3:0] nop[9];
		int s0;
		nop = '{4'h0, 4'h8, 4'hC, 4'hD, 4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
		void'($urandom(49));
		repeat (2) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		check(afe, 7'b0000100);
		rd_exp(ADDR_CTRL_HI, 8'hA0);
		rd_exp(ADDR_CTRL_LO, 8'h00);
		rd_exp(ADDR_FLAGS, 8'h00);
		i_isc_host.wr(DEV ^ 7'h01, ADDR_CTRL_HI, 8'h10, ok);
		check(ok, 0);
		first = 24'($urandom);
		step = 24'($urandom);
		for (int i = 0; i < 3; i++)
		begin
			wr(ADDR_FIRST_2 + 8'(i), first[23 - 8 * i -: 8]);
			wr(ADDR_STEP_2 + 8'(i), step[23 - 8 * i -: 8]);
			rd_exp(ADDR_FIRST_2 + 8'(i), first[23 - 8 * i -: 8]);
		end
		rd_exp(8'h90, 8'h00);
		wr(ADDR_PTS_HI, 8'hFE);
		wr(ADDR_PTS_LO, 8'h01);
		wr(ADDR_CTRL_LO, 8'h08);
		for (int i = 0; i < 8; i++)
		begin
			wr(ADDR_CTRL_HI, {CMD_STBY, 1'b0, 3'(i)});
			repeat (3) @(negedge clk_sys_in);
			check(afe, {3'(i), 4'b1110});
		end
		rd_exp(ADDR_CTRL_LO, 8'h08);
		wr(ADDR_SETTLE_HI, 8'h00);
		wr(ADDR_SETTLE_LO, 8'h00);
		wr(ADDR_CTRL_HI, {CMD_INIT, 4'h0});
		wr(ADDR_CTRL_HI, {CMD_INC, 4'h0});
		exc_en = 1'b1;
		repeat (60) @(negedge clk_sys_in);
		exc_en = 1'b0;
		check(starts, 0);
		check(freq, first);
		check(afe, 7'b0001011);
		measure(CMD_SWEEP, 2'b00, first, 1'b0, 1'b0);
		measure(CMD_REPEAT, MULT_X2, first, 1'b0, 1'b0);
		measure(CMD_INC, 2'b10, first + step, 1'b0, 1'b1);
		measure(CMD_REPEAT, MULT_X4, first + step, 1'b1, 1'b1);
		s0 = starts;
		foreach (nop[i])
		begin
			wr(ADDR_CTRL_HI, {nop[i], 4'h8});
			exc_en = 1'b1;
			repeat (20) @(negedge clk_sys_in);
			exc_en = 1'b0;
			check(freq, first + step);
			check(afe, 7'b0001011);
		end
		check(starts, s0);
		wr(ADDR_CTRL_HI, {CMD_INC, 4'h0});
		wr(ADDR_CTRL_LO, 8'h18);
		exc_en = 1'b1;
		repeat (80) @(negedge clk_sys_in);
		exc_en = 1'b0;
		check(starts, s0);
		rd_exp(ADDR_FLAGS, 8'h00);
		rd_exp(ADDR_FIRST_0, first[7:0]);
		wr(ADDR_CTRL_LO, 8'h08);
		wr(ADDR_CTRL_HI, {CMD_PDOWN, 4'h0});
		repeat (3) @(negedge clk_sys_in);
		check(afe, 7'b0001100);
		wr(ADDR_CTRL_HI, {CMD_TEMP, 4'h0});
		check(temp_pwr, 1'b0);
		rd_exp(ADDR_TEMP_HI, {{2{tcode[13]}}, tcode[13:8]});
		rd_exp(ADDR_TEMP_LO, tcode[7:0]);
		rd_exp(ADDR_FLAGS, 8'h01);
		wrap_up();
	end
endmodule

bind isc_ctrl isc_ctrl_props i_isc_ctrl_props (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .temp_done_in(temp_done_in), .afe_out(afe_out),
	.adc_start_out(adc_start_out), .temp_start_out(temp_start_out), .temp_sensor_power_out(temp_sensor_power_out));
`default_nettype wire
